// >>> core/dso_output_eval.sv
`timescale 1ns/1ps
`include "dso_map.svh"
module dso_output_eval
  import dso_pkg::*;
#(
  parameter int CLOCK_HZ = `DSO_CLOCK_HZ,
  parameter int BAUD_HZ  = `DSO_BAUD_HZ
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Measurement
  input  wire logic [15:0] distance,
  input  wire logic [7:0]  scale,
  input  wire logic        sample_valid,
  // Configuration and commands
  input  wire dso_mode_t   mode,
  input  wire logic        cmd_valid,
  input  wire dso_cmd_t    cmd,
  input  wire logic        teach_plus_pct,
  // Link mode and multifunction pin
  input  wire logic        link_mode,
  input  wire logic        sync_pin,
  input  wire logic        tool_req,
  // Outputs
  output logic             switched_out,
  output logic [31:0]      process_data,
  output logic             pd_valid,
  output logic             sync_pulse,
  output logic             tool_grant,
  output logic             bit_tick,
  output logic [15:0]      first_setpoint,
  output logic [15:0]      second_setpoint
);

  localparam int BIT_CYCLES = (CLOCK_HZ + BAUD_HZ - 1) / BAUD_HZ;
  // Last count of one bit period
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

  // Integer division truncates toward zero, so margins round toward zero
  // Raise a distance by the eight percent margin
  function automatic logic signed [15:0] plus_pct(input logic signed [15:0] v);
    logic signed [31:0] t;
    t = 32'(v) * 32'(`DSO_PCT_BASE + `DSO_MARGIN_PCT) / 32'(`DSO_PCT_BASE);
    return t[15:0];
  endfunction
  // Lower a distance by the eight percent margin
  function automatic logic signed [15:0] minus_pct(input logic signed [15:0] v);
    logic signed [31:0] t;
    t = 32'(v) * 32'(`DSO_PCT_BASE - `DSO_MARGIN_PCT) / 32'(`DSO_PCT_BASE);
    return t[15:0];
  endfunction

  // Inclusive range test that accepts either bound order
  function automatic logic in_window(input logic signed [15:0] v,
                                     input logic signed [15:0] a,
                                     input logic signed [15:0] b);
    return (v >= a && v <= b) || (v >= b && v <= a);
  endfunction

  // Latched sample and taught setpoints
  logic signed [15:0] sp1_q;
  logic signed [15:0] sp2_q;
  logic signed [15:0] dist_q;
  logic [7:0]         scale_q;
  // Eight percent bounds around the first setpoint
  logic signed [15:0] sp1_up;
  logic signed [15:0] sp1_dn;
  // Output state and its next value
  logic               out_q;
  logic               out_d;
  // Pin synchroniser stages
  logic               sync_m_q;
  logic               sync_s_q;
  logic               sync_p_q;
  logic               tool_m_q;
  logic               tool_s_q;
  // Bit-rate divider
  logic [15:0]        baud_cnt_q;

  assign first_setpoint  = sp1_q;
  assign second_setpoint = sp2_q;
  // Margins computed once, shared by the two percent modes
  assign sp1_up          = plus_pct(sp1_q);
  assign sp1_dn          = minus_pct(sp1_q);

  // Latch measurement sample
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      dist_q  <= 16'sh0000;
      scale_q <= 8'h00;
    end
    else if (sample_valid)
    begin
      dist_q  <= distance;
      scale_q <= scale;
    end

  // Setpoint teach and factory reset
  // Teach takes the latched distance; a sample in the same cycle is not seen yet
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      sp1_q <= `DSO_FACTORY_SP1;
      sp2_q <= `DSO_FACTORY_SP2;
    end
    else if (cmd_valid)
    begin
      case (cmd)
        DSO_CMD_TEACH_SP1: sp1_q <= teach_plus_pct ? plus_pct(dist_q) : dist_q;
        DSO_CMD_TEACH_SP2: sp2_q <= teach_plus_pct ? plus_pct(dist_q) : dist_q;
        DSO_CMD_FACTORY:
        begin
          sp1_q <= `DSO_FACTORY_SP1;
          sp2_q <= `DSO_FACTORY_SP2;
        end
        default: ;
      endcase
    end

  // Switching evaluation per mode
  always_comb
  begin
    out_d = 1'b0;
    case (mode)
      DSO_MODE_SINGLE:     out_d = dist_q < sp1_q;
      DSO_MODE_WINDOW:     out_d = in_window(dist_q, sp1_q, sp2_q);
      // Between the setpoints the last state is kept, giving hysteresis
      DSO_MODE_TWO_POINT:
      begin
        if (dist_q < sp1_q)
          out_d = 1'b1;
        else if (dist_q > sp2_q)
          out_d = 1'b0;
        else
          out_d = out_q;
      end
      DSO_MODE_SINGLE_PCT: out_d = dist_q < sp1_up;
      DSO_MODE_WINDOW_PCT: out_d = !in_window(dist_q, sp1_dn, sp1_up);
      default:             out_d = 1'b0;
    endcase
  end

  // Output state
  always_ff @(posedge clock or posedge rst)
    if (rst)
      out_q <= 1'b0;
    else
      out_q <= out_d;

  assign switched_out = out_q;

  // Process-data word packing
  // Bit 0 comes from out_d so it changes on the same edge as switched_out
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      process_data <= 32'h0000_0000;
      pd_valid     <= 1'b0;
    end
    else
    begin
      process_data                                <= 32'h0000_0000;
      process_data[`DSO_PD_OUT_BIT]               <= out_d;
      process_data[`DSO_PD_SCALE_LSB +: 8]        <= scale_q;
      process_data[`DSO_PD_VALUE_LSB +: 16]       <= dist_q;
      pd_valid                                    <= 1'b1;
    end

  // Pin synchronisers
  // Only the second stage feeds logic; the third marks the rising edge
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_p_q <= 1'b0;
      tool_m_q <= 1'b0;
      tool_s_q <= 1'b0;
    end
    else
    begin
      sync_m_q <= sync_pin;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
      tool_m_q <= tool_req;
      tool_s_q <= tool_m_q;
    end

  // Pin paths blocked in link mode
  // Link mode is a same-clock level, so the block acts in the same cycle
  assign sync_pulse = sync_s_q & ~sync_p_q & ~link_mode;
  assign tool_grant = tool_s_q & ~link_mode;

  // Link bit timing
  // Period rounded up so the bit rate never runs above the link rate
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      baud_cnt_q <= 16'h0000;
      bit_tick   <= 1'b0;
    end
    else if (baud_cnt_q == BIT_LAST)
    begin
      baud_cnt_q <= 16'h0000;
      bit_tick   <= 1'b1;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
      bit_tick   <= 1'b0;
    end

endmodule

// >>> core/dso_map.svh
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH
// Process-data word field positions
`define DSO_PD_OUT_BIT     0
`define DSO_PD_SCALE_LSB   8
`define DSO_PD_VALUE_LSB   16
`define DSO_PD_BYTES       4
// Eight percent margin as a ratio numerator over 100
`define DSO_MARGIN_PCT     8
`define DSO_PCT_BASE       100
// Link rate and device clock, in Hz
`define DSO_CLOCK_HZ       25000000
`define DSO_BAUD_HZ        38400
// Factory setpoints, in 0.1 mm units
`define DSO_FACTORY_SP1    16'sd2500
`define DSO_FACTORY_SP2    16'sd2500
`endif

// >>> core/dso_pkg.sv
package dso_pkg;
  // Switching evaluation modes
  typedef enum logic [4:0] {
    DSO_MODE_SINGLE     = 5'b00001,
    DSO_MODE_WINDOW     = 5'b00010,
    DSO_MODE_TWO_POINT  = 5'b00100,
    DSO_MODE_SINGLE_PCT = 5'b01000,
    DSO_MODE_WINDOW_PCT = 5'b10000
  } dso_mode_t;
  // System commands from the master
  typedef enum logic [1:0] {
    DSO_CMD_TEACH_SP1 = 2'h0,
    DSO_CMD_TEACH_SP2 = 2'h1,
    DSO_CMD_FACTORY   = 2'h2,
    DSO_CMD_NONE      = 2'h3
  } dso_cmd_t;
endpackage

// >>> verification/dso_output_eval_assertions.sv
`timescale 1ns/1ps
// Port checks of the switching evaluator
module dso_eval_chk
  import dso_pkg::*;
(
  // Inputs
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [15:0] distance,
  input wire logic [7:0]  scale,
  input wire logic        sample_valid,
  input wire dso_mode_t   mode,
  input wire logic        cmd_valid,
  input wire dso_cmd_t    cmd,
  input wire logic        link_mode,
  // Outputs
  input wire logic        switched_out,
  input wire logic [31:0] process_data,
  input wire logic        tool_grant,
  input wire logic        sync_pulse,
  input wire logic        pd_valid,
  input wire logic        bit_tick,
  input wire logic [15:0] first_setpoint,
  input wire logic [15:0] second_setpoint
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Sample taken two edges back
  sequence s_smp;
    sample_valid ##2 1'b1;
  endsequence
  out_bit_a: assert property (process_data[0] == switched_out) else $error("bit0");
  pad_zero_a: assert property (process_data[7:1] == 7'h0) else $error("pad");
  scale_fld_a: assert property (s_smp |-> process_data[15:8] == $past(scale, 2)) else $error("scale");
  dist_fld_a: assert property (s_smp |-> process_data[31:16] == $past(distance, 2)) else $error("dist");
  single_pt_a: assert property (s_smp ##0 mode == DSO_MODE_SINGLE |->
    switched_out == ($signed($past(distance, 2)) < $signed(first_setpoint))) else $error("single");
  link_off_a: assert property (link_mode && $past(link_mode) |-> !tool_grant) else $error("link");
  link_sync_a: assert property (link_mode |-> !sync_pulse) else $error("link sync");
  pd_live_a: assert property (!$past(rst) |-> pd_valid) else $error("pd valid");
  factory_set_a: assert property (cmd_valid && cmd == DSO_CMD_FACTORY |=>
    first_setpoint == 16'h09c4 && second_setpoint == 16'h09c4) else $error("factory");
  tick_gap_a: assert property (bit_tick |-> ##[652:652] bit_tick) else $error("tick");
endmodule
bind dso_output_eval dso_eval_chk chk (.*);

// >>> verification/dso_master_model.sv
`timescale 1ns/1ps
module dso_master_model (
  // Link side
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        bit_tick,
  input wire logic [31:0] process_data,
  // Last polled word
  output logic [31:0]     pd_rx_q
);
  // Poll the four-byte word each bit tick
  always_ff @(posedge clock or posedge rst)
    pd_rx_q <= rst ? 32'h0 : bit_tick ? process_data : pd_rx_q;
endmodule

// >>> verification/distance_switch_output_eval_test.sv
`timescale 1ns/1ps
module distance_switch_output_eval_test;
  import dso_pkg::*;
  logic clock = 0, rst = 1, sample_valid = 0, cmd_valid = 0, teach_plus_pct = 0, link_mode = 0, sync_pin = 0;
  logic tool_req = 0, switched_out, pd_valid, sync_pulse, tool_grant, bit_tick, v1, v2, v3, st = 0;
  logic [15:0] distance = 16'h0, first_setpoint, second_setpoint, sp1 = 16'h09c4, sp2 = 16'h09c4;
  logic [7:0] scale = 8'h0;
  logic [31:0] process_data, pd_rx, exp_q[$];
  dso_mode_t mode = DSO_MODE_TWO_POINT;
  dso_cmd_t cmd = DSO_CMD_NONE;
  integer seed = 14728, n_errors = 0, checked = 0, i, k;
  // Clock, design and master
  always #20 clock = ~clock;
  dso_output_eval DUT (.*);
  dso_master_model master (.clock, .rst, .bit_tick, .process_data, .pd_rx_q(pd_rx));
  task chk(input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One sample; odd distances never hit an even threshold
  task smp(input logic [15:0] d);
    @(negedge clock);
    distance = d;
    scale = 8'($random(seed));
    sample_valid = 1;
    case (mode)
      DSO_MODE_SINGLE: st = d < sp1;
      DSO_MODE_WINDOW: st = (d > sp1) != (d > sp2);
      DSO_MODE_SINGLE_PCT: st = d < 32'(sp1) * 108 / 100;
      DSO_MODE_WINDOW_PCT: st = d < 32'(sp1) * 92 / 100 || d > 32'(sp1) * 108 / 100;
      default: st = d < sp1 ? 1'b1 : d > sp2 ? 1'b0 : st;
    endcase
    exp_q.push_back({d, scale, 7'h0, st});
    @(negedge clock);
    sample_valid = 0;
    repeat (2) @(negedge clock);
  endtask
  task teach(input dso_cmd_t c, input logic p);
    @(negedge clock);
    cmd = c;
    teach_plus_pct = p;
    cmd_valid = 1;
    @(negedge clock);
    cmd_valid = 0;
    @(negedge clock);
  endtask
  // Result monitor, three edges after each sample
  always @(posedge clock)
  begin
    v1 <= sample_valid;
    v2 <= v1;
    v3 <= v2;
  end
  always @(negedge clock)
    if (v3 === 1'b1)
      chk(exp_q.pop_front(), process_data);
  // Main sequence
  initial
  begin
    repeat (5) @(negedge clock);
    rst = 0;
    smp(16'd4000);
    teach(DSO_CMD_TEACH_SP2, 0);
    sp2 = 16'd4000;
    smp(sp1);
    teach(DSO_CMD_TEACH_SP1, 1);
    sp1 = 16'd2700;
    st = 1'b1; // Latched 2500 now lies below the raised first setpoint
    teach(DSO_CMD_NONE, 0);
    chk({sp1, sp2}, {first_setpoint, second_setpoint});
    $display("teach done");
    for (k = 0; k < 5; k++)
    begin
      for (i = 0; i < 10; i++)
        smp(16'($random(seed)) & 16'h1fff | 16'h1);
      $display("mode %h done", mode);
      mode = dso_mode_t'(5'h1 << (k + (k > 1)));
    end
    teach(DSO_CMD_FACTORY, 0);
    chk(32'h09c409c4, {first_setpoint, second_setpoint});
    // Both pin paths open outside link mode, a sync edge gives one pulse
    tool_req = 1;
    sync_pin = 1;
    repeat (2) @(negedge clock);
    chk(32'h3, {30'h0, tool_grant, sync_pulse});
    @(negedge clock);
    chk(32'h2, {30'h0, tool_grant, sync_pulse});
    sync_pin = 0;
    repeat (3) @(negedge clock);
    // In link mode a fresh sync edge and the tool request are blocked
    link_mode = 1;
    sync_pin = 1;
    repeat (2) @(negedge clock);
    chk(32'h0, 32'(tool_grant | sync_pulse));
    $display("commands and link done");
    repeat (1400) @(negedge clock);
    chk(32'h0, 32'(exp_q.size()));
    chk({distance, scale, 8'h00}, pd_rx);
    // Mid-run reset after a teach restores factory setpoints
    teach(DSO_CMD_TEACH_SP2, 0);
    rst = 1;
    @(negedge clock);
    chk(32'h09c409c4, {first_setpoint, second_setpoint});
    chk(32'h0, process_data | {29'h0, switched_out, pd_valid, bit_tick});
    rst = 0;
    @(negedge clock);
    chk(32'h1, 32'(pd_valid));
    $display("reset done");
    finish_test;
  end
  // Hang limit
  initial
  begin
    #1000000;
    n_errors++;
    finish_test;
  end
endmodule
